// ---- inc/awh_pkg.sv ----
// Operation
// - CDh runs multiple write without erase
// - 30h writes 1..256 sectors, zero means 256
// - write starts at task-file address
// - accept: BSY, then DRQ with BSY clear
// - first DRQ raises no interrupt
// - per sector BSY; next buffer DRQ plus interrupt
// - last sector: BSY until done, then interrupt
// - error stops write, failing address kept
// - 38h same handshake, no implied erase
// - sector not pre-erased gets normal write
// - SMART operation chosen by feature value
// - unsupported SMART feature is aborted
// - multiple write aborted unless configured, enabled
// - only block size one is supported
package awh_pkg;
  // ****************************************************
  // register map, byte addresses
  // ****************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DRV = 8'h04;
  localparam logic [7:0] OFS_A23 = 8'h08;
  localparam logic [7:0] OFS_A15 = 8'h0c;
  localparam logic [7:0] OFS_A7 = 8'h10;
  localparam logic [7:0] OFS_CNT = 8'h14;
  localparam logic [7:0] OFS_FEAT = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_ERR = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h24;
  localparam logic [7:0] OFS_CFG = 8'h28;
  localparam logic [7:0] OFS_ISTAT = 8'h2c;
  localparam logic [7:0] OFS_IMASK = 8'h30;
  // ****************************************************
  // opcodes and sub-operations
  // ****************************************************
  localparam logic [7:0] OP_WRITE = 8'h30;
  localparam logic [7:0] OP_WRITE_NE = 8'h38;
  localparam logic [7:0] OP_WMULT_NE = 8'hcd;
  localparam logic [7:0] OP_SMART = 8'hb0;
  localparam logic [7:0] SM_READ = 8'hd0;
  localparam logic [7:0] SM_THRESH = 8'hd1;
  localparam logic [7:0] SM_AUTOSAVE = 8'hd2;
  localparam logic [7:0] SM_SAVE = 8'hd3;
  localparam logic [7:0] SM_OFFLINE = 8'hd4;
  localparam logic [7:0] SM_ENABLE = 8'hd8;
  localparam logic [7:0] SM_DISABLE = 8'hd9;
  localparam logic [7:0] SM_STATUS = 8'hda;
  // ****************************************************
  // field positions, reset values, counts
  // ****************************************************
  localparam int ST_BSY = 7;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int ER_MEDIA = 6;
  localparam int CFG_MODE_SET = 0;
  localparam int CFG_MULT_EN = 1;
  localparam int CFG_BLK_LSB = 8;
  localparam logic [7:0] BLOCK_ONE = 8'h01;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int EV_DRQ = 0;
  localparam int EV_DONE = 1;
  localparam int EV_ERR = 2;
  localparam int EV_W = 3;
  localparam logic [6:0] LAST_WORD = 7'h7f; // 128 words of 32 bits
  localparam logic [8:0] COUNT_MAX = 9'h100;
  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ACCEPT = 3'b001,
    S_XFER = 3'b010,
    S_PROG = 3'b011,
    S_WAIT = 3'b100
  } awh_state_t;

  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] a23;
    logic [7:0] a15;
    logic [7:0] a7;
    logic [7:0] cnt;
    logic [7:0] feat;
  } awh_tf_t;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } awh_apb_t;

  function automatic logic smart_ok(input logic [7:0] f);
    smart_ok = (f == SM_READ) || (f == SM_THRESH) ||
      (f == SM_AUTOSAVE) || (f == SM_SAVE) || (f == SM_OFFLINE) ||
      (f == SM_ENABLE) || (f == SM_DISABLE) || (f == SM_STATUS);
  endfunction
endpackage

// ---- src/awh_irq.sv ----
`timescale 1ns/100ps
// sticky event bits, write-one-to-clear, mask, level output
module awh_irq #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] ev,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic irq;
  } awh_irq_st_t;

  awh_irq_st_t r_q;
  awh_irq_st_t r_d;

  // a new event beats a clear in the same cycle
  always_comb
  begin
    r_d = r_q;
    r_d.status = (r_q.status & ~(clr_we ? wdata : '0)) | ev;
    if (mask_we)
    begin
      r_d.mask = wdata;
    end
    r_d.irq = |(r_d.status & r_d.mask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign status = r_q.status;
  assign mask = r_q.mask;
  assign irq = r_q.irq;
endmodule // awh_irq

// ---- src/awh_core.sv ----
`timescale 1ns/100ps
module awh_core (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic BSY,
  output logic DRQ,
  output logic MEDIA_REQ,
  output logic [27:0] MEDIA_LBA,
  output logic MEDIA_ERASE,
  input wire logic MEDIA_PREERASED,
  input wire logic MEDIA_DONE,
  input wire logic MEDIA_ERR,
  output logic SMART_REQ,
  output logic [7:0] SMART_FEATURE
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    awh_pkg::awh_state_t st;
    awh_pkg::awh_tf_t tf;
    logic [7:0] cmd;
    logic [8:0] remaining;
    logic [6:0] words;
    logic [7:0] err;
    logic [15:0] cfg;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic bsy;
    logic drq;
    logic media_req;
    logic [27:0] media_lba;
    logic media_erase;
    logic smart_req;
    logic [7:0] smart_feat;
    logic [awh_pkg::EV_W-1:0] ev;
  } awh_core_st_t;

  awh_core_st_t r_q;
  awh_core_st_t r_d;
  awh_pkg::awh_apb_t req;
  logic acc;
  logic wr_acc;
  logic [27:0] lba;
  logic [awh_pkg::EV_W-1:0] irq_status;
  logic [awh_pkg::EV_W-1:0] irq_mask;
  logic irq_out;

  assign req = '{sel: PSEL, en: PENABLE, wr: PWRITE, addr: PADDR,
    wdata: PWDATA};
  // the completing edge: pready was already high
  assign acc = req.sel && req.en && r_q.pready;
  assign wr_acc = acc && req.wr;
  // linear address from head nibble and three bytes
  assign lba = {r_q.tf.drv[3:0], r_q.tf.a23, r_q.tf.a15,
    r_q.tf.a7};

  // ****************************************************
  // interrupt status and mask
  // ****************************************************
  awh_irq #(
    .W(awh_pkg::EV_W)
  ) u_irq (
    .clk(CLK),
    .rst(SYS_RST),
    .ev(r_q.ev),
    .clr_we(wr_acc && req.addr == awh_pkg::OFS_ISTAT),
    .mask_we(wr_acc && req.addr == awh_pkg::OFS_IMASK),
    .wdata(req.wdata[awh_pkg::EV_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq_out)
  );

  // ****************************************************
  // next state: bus slave and command sequencer
  // ****************************************************
  always_comb
  begin
    r_d = r_q;
    r_d.media_req = 1'b0;
    r_d.smart_req = 1'b0;
    r_d.ev = '0;
    // one wait state keeps every bus output on a flop
    r_d.pready = req.sel && req.en && !r_q.pready;
    r_d.prdata = 32'h0000_0000;
    r_d.pslverr = 1'b0;
    if (req.addr == awh_pkg::OFS_STAT)
    begin
      r_d.prdata[awh_pkg::ST_BSY] = r_q.bsy;
      r_d.prdata[awh_pkg::ST_DRQ] = r_q.drq;
      r_d.prdata[awh_pkg::ST_ERR] = |r_q.err;
    end
    else if (req.addr == awh_pkg::OFS_ERR)
    begin
      r_d.prdata[7:0] = r_q.err;
    end
    else if (req.addr == awh_pkg::OFS_DRV)
    begin
      r_d.prdata[7:0] = r_q.tf.drv;
    end
    else if (req.addr == awh_pkg::OFS_A23)
    begin
      r_d.prdata[7:0] = r_q.tf.a23;
    end
    else if (req.addr == awh_pkg::OFS_A15)
    begin
      r_d.prdata[7:0] = r_q.tf.a15;
    end
    else if (req.addr == awh_pkg::OFS_A7)
    begin
      r_d.prdata[7:0] = r_q.tf.a7;
    end
    else if (req.addr == awh_pkg::OFS_CNT)
    begin
      r_d.prdata[7:0] = r_q.tf.cnt;
    end
    else if (req.addr == awh_pkg::OFS_CFG)
    begin
      r_d.prdata[15:0] = r_q.cfg;
    end
    else if (req.addr == awh_pkg::OFS_ISTAT)
    begin
      r_d.prdata[awh_pkg::EV_W-1:0] = irq_status;
    end
    else if (req.addr == awh_pkg::OFS_IMASK)
    begin
      r_d.prdata[awh_pkg::EV_W-1:0] = irq_mask;
    end
    else if (req.addr != awh_pkg::OFS_CMD &&
      req.addr != awh_pkg::OFS_FEAT &&
      req.addr != awh_pkg::OFS_DATA)
    begin
      r_d.pslverr = r_d.pready;
    end
    // task file and config writes only while idle
    if (wr_acc && r_q.st == awh_pkg::S_IDLE)
    begin
      if (req.addr == awh_pkg::OFS_DRV)
      begin
        r_d.tf.drv = req.wdata[7:0];
      end
      else if (req.addr == awh_pkg::OFS_A23)
      begin
        r_d.tf.a23 = req.wdata[7:0];
      end
      else if (req.addr == awh_pkg::OFS_A15)
      begin
        r_d.tf.a15 = req.wdata[7:0];
      end
      else if (req.addr == awh_pkg::OFS_A7)
      begin
        r_d.tf.a7 = req.wdata[7:0];
      end
      else if (req.addr == awh_pkg::OFS_CNT)
      begin
        r_d.tf.cnt = req.wdata[7:0];
      end
      else if (req.addr == awh_pkg::OFS_FEAT)
      begin
        r_d.tf.feat = req.wdata[7:0];
      end
      else if (req.addr == awh_pkg::OFS_CFG)
      begin
        r_d.cfg = req.wdata[15:0];
      end
      else if (req.addr == awh_pkg::OFS_CMD)
      begin
        r_d.cmd = req.wdata[7:0];
        r_d.err = 8'h00;
        r_d.words = 7'h00;
        r_d.remaining = (r_q.tf.cnt == 8'h00) ? awh_pkg::COUNT_MAX :
          {1'b0, r_q.tf.cnt};
        case (req.wdata[7:0])
          awh_pkg::OP_WRITE,
          awh_pkg::OP_WRITE_NE:
          begin
            r_d.st = awh_pkg::S_ACCEPT;
          end
          awh_pkg::OP_WMULT_NE:
          begin
            // block mode must be set, enabled and of size one
            if (r_q.cfg[awh_pkg::CFG_MODE_SET] &&
              r_q.cfg[awh_pkg::CFG_MULT_EN] &&
              r_q.cfg[awh_pkg::CFG_BLK_LSB +: 8] == awh_pkg::BLOCK_ONE)
            begin
              r_d.st = awh_pkg::S_ACCEPT;
            end
            else
            begin
              r_d.err[awh_pkg::ER_ABRT] = 1'b1;
              r_d.ev[awh_pkg::EV_ERR] = 1'b1;
            end
          end
          awh_pkg::OP_SMART:
          begin
            if (awh_pkg::smart_ok(r_q.tf.feat))
            begin
              r_d.smart_req = 1'b1;
              r_d.smart_feat = r_q.tf.feat;
              r_d.ev[awh_pkg::EV_DONE] = 1'b1;
            end
            else
            begin
              r_d.err[awh_pkg::ER_ABRT] = 1'b1;
              r_d.ev[awh_pkg::EV_ERR] = 1'b1;
            end
          end
          default:
          begin
            r_d.err[awh_pkg::ER_ABRT] = 1'b1;
            r_d.ev[awh_pkg::EV_ERR] = 1'b1;
          end
        endcase
      end
    end
    case (r_q.st)
      awh_pkg::S_ACCEPT:
      begin
        // first buffer opens silently
        r_d.st = awh_pkg::S_XFER;
      end
      awh_pkg::S_XFER:
      begin
        // the host keeps off the data port until DRQ
        if (wr_acc && req.addr == awh_pkg::OFS_DATA)
        begin
          r_d.words = r_q.words + 7'h01;
          if (r_q.words == awh_pkg::LAST_WORD)
          begin
            r_d.st = awh_pkg::S_PROG;
          end
        end
      end
      awh_pkg::S_PROG:
      begin
        r_d.media_req = 1'b1;
        r_d.media_lba = lba;
        // erase unless skipped and the sector is clean
        r_d.media_erase = (r_q.cmd == awh_pkg::OP_WRITE) ||
          !MEDIA_PREERASED;
        r_d.st = awh_pkg::S_WAIT;
      end
      awh_pkg::S_WAIT:
      begin
        if (MEDIA_DONE && MEDIA_ERR)
        begin
          // address registers still name the failing sector
          r_d.err[awh_pkg::ER_MEDIA] = 1'b1;
          r_d.ev[awh_pkg::EV_ERR] = 1'b1;
          r_d.st = awh_pkg::S_IDLE;
        end
        else if (MEDIA_DONE)
        begin
          {r_d.tf.drv[3:0], r_d.tf.a23, r_d.tf.a15, r_d.tf.a7} =
            lba + 28'h000_0001;
          r_d.remaining = r_q.remaining - 9'h001;
          r_d.tf.cnt = r_d.remaining[7:0];
          r_d.words = 7'h00;
          if (r_q.remaining == 9'h001)
          begin
            r_d.ev[awh_pkg::EV_DONE] = 1'b1;
            r_d.st = awh_pkg::S_IDLE;
          end
          else
          begin
            r_d.ev[awh_pkg::EV_DRQ] = 1'b1;
            r_d.st = awh_pkg::S_XFER;
          end
        end
      end
      default:
      begin
      end
    endcase
    // BSY covers acceptance and each programming phase
    r_d.bsy = (r_d.st == awh_pkg::S_ACCEPT) ||
      (r_d.st == awh_pkg::S_PROG) || (r_d.st == awh_pkg::S_WAIT);
    r_d.drq = (r_d.st == awh_pkg::S_XFER);
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      r_q <= '0;
      r_q.cfg <= awh_pkg::CFG_RESET;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign PRDATA = r_q.prdata;
  assign PREADY = r_q.pready;
  assign PSLVERR = r_q.pslverr;
  assign IRQ = irq_out;
  assign BSY = r_q.bsy;
  assign DRQ = r_q.drq;
  assign MEDIA_REQ = r_q.media_req;
  assign MEDIA_LBA = r_q.media_lba;
  assign MEDIA_ERASE = r_q.media_erase;
  assign SMART_REQ = r_q.smart_req;
  assign SMART_FEATURE = r_q.smart_feat;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  logic cmd_wr;
  logic done_ok;
  assign cmd_wr = wr_acc && req.addr == awh_pkg::OFS_CMD &&
    r_q.st == awh_pkg::S_IDLE;
  assign done_ok = r_q.st == awh_pkg::S_WAIT && MEDIA_DONE && !MEDIA_ERR;

  a_accept_bsy: assert property (
    cmd_wr && req.wdata[7:0] == awh_pkg::OP_WRITE
    |=> BSY && !DRQ ##1 DRQ && !BSY)
    else $error("write accept did not go BSY then DRQ");
  a_first_silent: assert property (
    r_q.st == awh_pkg::S_ACCEPT |=> !r_q.ev[awh_pkg::EV_DRQ] [*2])
    else $error("interrupt raised for first buffer");
  a_count_zero: assert property (
    cmd_wr && r_q.tf.cnt == 8'h00 && (req.wdata[7:0] == awh_pkg::OP_WRITE
    || req.wdata[7:0] == awh_pkg::OP_WRITE_NE)
    |=> r_q.remaining == 9'h100)
    else $error("zero count did not mean 256");
  a_sector_busy: assert property (
    r_q.st == awh_pkg::S_XFER && wr_acc && req.addr == awh_pkg::OFS_DATA
    && r_q.words == awh_pkg::LAST_WORD
    |=> BSY && !DRQ ##1 MEDIA_REQ && MEDIA_LBA == $past(lba))
    else $error("full sector did not start programming");
  a_next_drq: assert property (
    done_ok && r_q.remaining > 9'h001
    |=> DRQ && !BSY ##1 irq_status[awh_pkg::EV_DRQ])
    else $error("next buffer without DRQ interrupt");
  a_last_done: assert property (
    done_ok && r_q.remaining == 9'h001
    |=> !BSY && !DRQ ##1 irq_status[awh_pkg::EV_DONE])
    else $error("completion without interrupt");
  a_err_addr: assert property (
    r_q.st == awh_pkg::S_WAIT && MEDIA_DONE && MEDIA_ERR
    |=> $stable(lba) && r_q.err[awh_pkg::ER_MEDIA] && !BSY)
    else $error("error moved the address");
  a_skip_erase: assert property (
    r_q.st == awh_pkg::S_PROG && r_q.cmd != awh_pkg::OP_WRITE
    |=> MEDIA_ERASE == !$past(MEDIA_PREERASED))
    else $error("erase choice wrong for write without erase");
  a_mult_abort: assert property (
    cmd_wr && req.wdata[7:0] == awh_pkg::OP_WMULT_NE &&
    !r_q.cfg[awh_pkg::CFG_MODE_SET]
    |=> r_q.err[awh_pkg::ER_ABRT] && r_q.st == awh_pkg::S_IDLE)
    else $error("unconfigured multiple write not aborted");
  a_smart_bad: assert property (
    cmd_wr && req.wdata[7:0] == awh_pkg::OP_SMART &&
    !awh_pkg::smart_ok(r_q.tf.feat)
    |=> r_q.err[awh_pkg::ER_ABRT] && !SMART_REQ)
    else $error("bad SMART feature not aborted");

  c_full_write: cover property (done_ok && r_q.remaining == 9'h001);
  c_media_err: cover property (r_q.st == awh_pkg::S_WAIT && MEDIA_ERR
    && MEDIA_DONE);
  c_smart: cover property (SMART_REQ);
endmodule // awh_core

// ---- test/awh_media_model.sv ----
`timescale 1ns/100ps
// flash side: answers each program request after a chosen delay
module awh_media_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [27:0] lba,
  input wire logic [3:0] delay,
  input wire logic fail_en,
  input wire logic [27:0] fail_lba,
  input wire logic erased_in,
  output logic done,
  output logic err,
  output logic erased
);
  logic busy_q;
  logic hit_q;
  logic [3:0] wait_q;

  // erase state of the addressed sectors as left by the host
  assign erased = erased_in;

  // err toggles while idle, since it only counts together with done
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      hit_q <= 1'b0;
      wait_q <= 4'h0;
    end
    else
    begin
      done <= 1'b0;
      err <= ~err;
      if (req)
      begin
        busy_q <= 1'b1;
        wait_q <= delay;
        hit_q <= fail_en && (lba == fail_lba);
      end
      else if (busy_q && wait_q == 4'h0)
      begin
        done <= 1'b1;
        err <= hit_q;
        busy_q <= 1'b0;
      end
      else if (busy_q)
        wait_q <= wait_q - 4'h1;
    end
  end
endmodule // awh_media_model

// ---- test/ata_write_cmd_handler_tb.sv ----
`timescale 1ns/100ps
module ata_write_cmd_handler_tb;
  // ****************************************************
  // signals and instances
  // ****************************************************
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] feat;
    logic [15:0] cfg;
    logic ok;
  } awh_row_t;
  logic CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PREADY, PSLVERR, IRQ, BSY, DRQ, MEDIA_REQ;
  logic [7:0] PADDR = 8'h00, SMART_FEATURE;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdata;
  logic [27:0] MEDIA_LBA, lba_seen, fail_lba = 28'h0;
  logic MEDIA_ERASE, MEDIA_PREERASED, MEDIA_DONE, MEDIA_ERR, SMART_REQ;
  logic slv, erase_seen, fail_en = 1'b0, erased = 1'b0;
  logic [7:0] sm_feat;
  logic [3:0] delay = 4'h0;
  int num_errors = 0, check_count = 0, req_n = 0, sm_n = 0, n0;
  awh_row_t rows [14] = '{'{8'hb0, 8'hd0, 16'h0, 1'b1},
    '{8'hb0, 8'hd1, 16'h0, 1'b1}, '{8'hb0, 8'hd2, 16'h0, 1'b1},
    '{8'hb0, 8'hd3, 16'h0, 1'b1}, '{8'hb0, 8'hd4, 16'h0, 1'b1},
    '{8'hb0, 8'hd8, 16'h0, 1'b1}, '{8'hb0, 8'hd9, 16'h0, 1'b1},
    '{8'hb0, 8'hda, 16'h0, 1'b1}, '{8'hb0, 8'hd5, 16'h0, 1'b0},
    '{8'h55, 8'h00, 16'h0, 1'b0}, '{8'hcd, 8'h00, 16'h0, 1'b0},
    '{8'hcd, 8'h00, 16'h0101, 1'b0}, '{8'hcd, 8'h00, 16'h0102, 1'b0},
    '{8'hcd, 8'h00, 16'h0203, 1'b0}};

  awh_core dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .BSY(BSY), .DRQ(DRQ), .MEDIA_REQ(MEDIA_REQ), .MEDIA_LBA(MEDIA_LBA),
    .MEDIA_ERASE(MEDIA_ERASE), .MEDIA_PREERASED(MEDIA_PREERASED),
    .MEDIA_DONE(MEDIA_DONE), .MEDIA_ERR(MEDIA_ERR),
    .SMART_REQ(SMART_REQ), .SMART_FEATURE(SMART_FEATURE));
  awh_media_model media_u (.clk(CLK), .rst(SYS_RST), .req(MEDIA_REQ),
    .lba(MEDIA_LBA), .delay(delay), .fail_en(fail_en),
    .fail_lba(fail_lba), .erased_in(erased), .done(MEDIA_DONE),
    .err(MEDIA_ERR), .erased(MEDIA_PREERASED));

  // free-running clock
  always #2 CLK = ~CLK;

  // capture of media and SMART requests for later comparison
  always @(posedge CLK)
  begin
    if (MEDIA_REQ === 1'b1)
    begin
      req_n <= req_n + 1;
      lba_seen <= MEDIA_LBA;
      erase_seen <= MEDIA_ERASE;
    end
    if (SMART_REQ === 1'b1)
    begin
      sm_n <= sm_n + 1;
      sm_feat <= SMART_FEATURE;
    end
  end
  // ****************************************************
  // tasks
  // ****************************************************
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; a bounded wait guards against a slave that never answers
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
    begin
      @(posedge CLK);
      n++;
      if (n > 50)
      begin
        chk("pready", 32'h1, 32'h0);
        report_and_stop();
      end
    end
    rdata = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // 0: DRQ set, 1: idle, 2: BSY set
  task waitk(input int k);
    int n;
    n = 0;
    while (!((k == 0) ? DRQ === 1'b1 : (k == 1) ?
      (BSY === 1'b0 && DRQ === 1'b0) : BSY === 1'b1))
    begin
      @(posedge CLK);
      n++;
      if (n > 300)
      begin
        chk("wait", k, 32'hffff);
        report_and_stop();
      end
    end
  endtask

  task tf(input logic [7:0] dv, a2, a1, a0, cn);
    wr(awh_pkg::OFS_DRV, {24'h0, dv});
    wr(awh_pkg::OFS_A23, {24'h0, a2});
    wr(awh_pkg::OFS_A15, {24'h0, a1});
    wr(awh_pkg::OFS_A7, {24'h0, a0});
    wr(awh_pkg::OFS_CNT, {24'h0, cn});
  endtask

  // data only after DRQ with BSY clear; then wait for the busy phase
  task sector();
    for (int i = 0; i < 128; i++)
      wr(awh_pkg::OFS_DATA, i);
    waitk(2);
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    repeat (12) @(posedge CLK);
    chk("reset outputs", 32'h0, {BSY, DRQ, IRQ, PREADY});
    SYS_RST <= 1'b0;
    rd(awh_pkg::OFS_STAT);
    chk("status", 32'h0, rdata);
    rd(awh_pkg::OFS_CFG);
    chk("cfg", {16'h0, awh_pkg::CFG_RESET}, rdata);
    rd(awh_pkg::OFS_CMD);
    chk("cmd read", 32'h0, rdata);
    rd(8'hfc);
    chk("unmapped", 32'h1, {rdata[30:0], slv});
    wr(awh_pkg::OFS_IMASK, 32'h7);
    // every SMART feature and every refused command
    for (int i = 0; i < 14; i++)
    begin
      wr(awh_pkg::OFS_CFG, {16'h0, rows[i].cfg});
      wr(awh_pkg::OFS_FEAT, {24'h0, rows[i].feat});
      n0 = sm_n;
      wr(awh_pkg::OFS_CMD, {24'h0, rows[i].op});
      rd(awh_pkg::OFS_ISTAT);
      chk("istat", rows[i].ok ? 32'h2 : 32'h4, rdata);
      rd(awh_pkg::OFS_ERR);
      chk("error", rows[i].ok ? 32'h0 : 32'h4, rdata);
      chk("smart reqs", {31'h0, rows[i].ok}, sm_n - n0);
      if (rows[i].ok)
        chk("feature", {24'h0, rows[i].feat}, sm_feat);
      chk("irq", 32'h1, IRQ);
      wr(awh_pkg::OFS_ISTAT, 32'h7);
      rd(awh_pkg::OFS_STAT);
      chk("stat err", rows[i].ok ? 32'h0 : 32'h1, rdata);
      chk("irq cleared", 32'h0, IRQ);
    end
    // two sectors with erase, address taken from the task file
    n0 = req_n;
    tf(8'he1, 8'h23, 8'h45, 8'hfe, 8'h02);
    wr(awh_pkg::OFS_CMD, {24'h0, awh_pkg::OP_WRITE});
    waitk(0);
    rd(awh_pkg::OFS_ISTAT);
    chk("first drq irq", 32'h0, {rdata[30:0], IRQ});
    sector();
    waitk(0);
    chk("lba", 32'h012345fe, lba_seen);
    chk("erase", 32'h1, erase_seen);
    rd(awh_pkg::OFS_ISTAT);
    chk("next drq irq", 32'h3, {rdata[30:0], IRQ});
    wr(awh_pkg::OFS_ISTAT, 32'h1);
    sector();
    waitk(1);
    chk("lba 2", 32'h012345ff, lba_seen);
    chk("sectors", 32'h2, req_n - n0);
    rd(awh_pkg::OFS_ISTAT);
    chk("done irq", 32'h2, rdata);
    wr(awh_pkg::OFS_ISTAT, 32'h2);
    // count zero, slow media, not erased, failure on the second sector
    delay <= 4'h9;
    fail_en <= 1'b1;
    fail_lba <= 28'h11;
    n0 = req_n;
    tf(8'he0, 8'h00, 8'h00, 8'h10, 8'h00);
    wr(awh_pkg::OFS_CMD, {24'h0, awh_pkg::OP_WRITE_NE});
    waitk(0);
    sector();
    waitk(0);
    chk("fallback erase", 32'h1, erase_seen);
    wr(awh_pkg::OFS_ISTAT, 32'h1);
    sector();
    waitk(1);
    chk("stopped", 32'h2, req_n - n0);
    rd(awh_pkg::OFS_ERR);
    chk("media error", 32'h40, rdata);
    rd(awh_pkg::OFS_A7);
    chk("fail address", 32'h11, rdata);
    rd(awh_pkg::OFS_CNT);
    chk("residual", 32'hff, rdata);
    rd(awh_pkg::OFS_ISTAT);
    chk("error irq", 32'h4, rdata);
    wr(awh_pkg::OFS_ISTAT, 32'h4);
    // configured multiple write on pre-erased sectors
    delay <= 4'h0;
    fail_en <= 1'b0;
    erased <= 1'b1;
    wr(awh_pkg::OFS_CFG, 32'h0103);
    tf(8'he0, 8'h00, 8'h00, 8'h20, 8'h01);
    wr(awh_pkg::OFS_CMD, {24'h0, awh_pkg::OP_WMULT_NE});
    waitk(0);
    sector();
    waitk(1);
    chk("no erase", 32'h0, erase_seen);
    chk("lba 3", 32'h20, lba_seen);
    rd(awh_pkg::OFS_ISTAT);
    chk("done irq 2", 32'h2, rdata);
    wr(awh_pkg::OFS_ISTAT, 32'h2);
    // masked event stays silent until unmasked
    wr(awh_pkg::OFS_IMASK, 32'h0);
    wr(awh_pkg::OFS_FEAT, 32'hda);
    wr(awh_pkg::OFS_CMD, 32'hb0);
    rd(awh_pkg::OFS_ISTAT);
    chk("masked", 32'h4, {rdata[30:0], IRQ});
    wr(awh_pkg::OFS_IMASK, 32'h7);
    rd(awh_pkg::OFS_IMASK);
    chk("unmasked", 32'hf, {rdata[30:0], IRQ});
    // task file is frozen while a command runs; reset then drops it all
    tf(8'he0, 8'h00, 8'h00, 8'h30, 8'h01);
    wr(awh_pkg::OFS_CMD, {24'h0, awh_pkg::OP_WRITE});
    waitk(0);
    wr(awh_pkg::OFS_A7, 32'h55);
    rd(awh_pkg::OFS_A7);
    chk("busy write", 32'h30, rdata);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    chk("mid reset", 32'h0, {BSY, DRQ, IRQ});
    rd(awh_pkg::OFS_CFG);
    chk("cfg after reset", 32'h0, rdata);
    report_and_stop();
  end
endmodule // ata_write_cmd_handler_tb
